// *** hdl/scr_params.svh ***
`ifndef SCR_PARAMS_SVH
`define SCR_PARAMS_SVH

`define SCR_OFF_CTRL     8'h00
`define SCR_OFF_STATUS   8'h04
`define SCR_OFF_INSTR    8'h08
`define SCR_OFF_ORIGIN   8'h0C
`define SCR_OFF_TARGET   8'h10
`define SCR_OFF_TALLY    8'h14

`define SCR_CTRL_START   0
`define SCR_ST_BUSY      0
`define SCR_ST_SUSP      1
`define SCR_ST_ERR       2
`define SCR_ST_DONE      3
`define SCR_ST_FLAGS     8

`define SCR_OP_BW_TOP    7'h5D
`define SCR_OP_LONG_TOP  8'hB9
`define SCR_OP_TAIL      4'h6
`define SCR_OP2_TOP      4'h0
`define SCR_NIBBLE_ZERO  4'h0

`define SCR_STEP_BYTE    32'h0000_0001
`define SCR_STEP_WORD    32'h0000_0002
`define SCR_STEP_LONG    32'h0000_0004

`define SCR_RST_WORD     32'h0000_0000
`define SCR_RST_TALLY    16'h0000
`define SCR_TALLY_ONE    16'h0001
`define SCR_RESP_OKAY    2'h0
`define SCR_RESP_SLVERR  2'h2

`endif

// *** hdl/scr_pkg.sv ***
`default_nettype none
package scr_pkg;
    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0,
        SZ_WORD = 2'h1,
        SZ_LONG = 2'h2
    } scr_size_t;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_RD_TGT = 4'b0010,
        ST_RD_ORG = 4'b0100,
        ST_EXEC   = 4'b1000
    } scr_state_t;

    // c borrow, z match, s negative, v count done
    typedef struct packed {
        logic c;
        logic z;
        logic s;
        logic v;
    } scr_flags_t;

    typedef struct packed {
        logic c;
        logic z;
        logic s;
        logic v;
    } scr_alu_t;

    typedef struct packed {
        logic      rd;
        logic [31:0] addr;
        scr_size_t size;
    } scr_mem_req_t;
endpackage
`default_nettype wire

// *** hdl/scr_compare.sv ***
`default_nettype none
module scr_compare (
    input  wire logic [31:0]       target_elem,
    input  wire logic [31:0]       origin_elem,
    input  wire scr_pkg::scr_size_t size,
    input  wire logic [3:0]        test_field,
    output logic                   match,
    output scr_pkg::scr_alu_t      alu
);
    import scr_pkg::*;

    logic [31:0] a;
    logic [31:0] b;
    logic [32:0] diff;
    logic        lt;
    logic        ule;

    // element sits in the top bits so one subtractor serves every size
    always_comb begin
        case (size)
            SZ_BYTE: begin
                a = {target_elem[7:0], 24'h00_0000};
                b = {origin_elem[7:0], 24'h00_0000};
            end
            SZ_WORD: begin
                a = {target_elem[15:0], 16'h0000};
                b = {origin_elem[15:0], 16'h0000};
            end
            default: begin
                a = target_elem;
                b = origin_elem;
            end
        endcase
        diff  = {1'b0, a} - {1'b0, b};
        alu.c = diff[32];
        alu.s = diff[31];
        alu.z = (diff[31:0] == 32'h0000_0000);
        alu.v = (a[31] ^ b[31]) & (diff[31] ^ a[31]);
        lt    = alu.s ^ alu.v;
        ule   = alu.c | alu.z;
        unique case (test_field)
            4'h0: match = 1'b0;
            4'h1: match = lt;
            4'h2: match = lt | alu.z;
            4'h3: match = ule;
            4'h4: match = alu.v;
            4'h5: match = alu.s;
            4'h6: match = alu.z;
            4'h7: match = alu.c;
            4'h8: match = 1'b1;
            4'h9: match = ~lt;
            4'hA: match = ~(lt | alu.z);
            4'hB: match = ~ule;
            4'hC: match = ~alu.v;
            4'hD: match = ~alu.s;
            4'hE: match = ~alu.z;
            4'hF: match = ~alu.c;
        endcase
    end
endmodule
`default_nettype wire

// *** hdl/scr_string_compare_repeat.sv ***
// Overview of operation
// - repeat step until condition or tally zero
// - advance both pointers by 1, 2, 4
// - subtract origin element from target, no writeback
// - match_flag set when condition holds, else cleared
// - word tally decremented once per step
// - tally of one gives exactly one compare
// - borrow_flag set on carry out, else clear
// - negative_flag follows sign of last result
// - count_done_flag set when tally reaches zero
`include "scr_params.svh"
`default_nettype none
module scr_string_compare_repeat (
    input  wire logic                clock,
    input  wire logic                reset_n,
    input  wire logic                clk_en,
    input  wire logic                irq_req,
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    output scr_pkg::scr_mem_req_t    mem_req,
    input  wire logic [31:0]         mem_rdata,
    input  wire logic                mem_rvalid,
    output logic                     busy
);
    import scr_pkg::*;

    scr_state_t   state_r;
    scr_mem_req_t mem_req_r;
    scr_flags_t   flags_r;
    scr_alu_t     alu;
    scr_size_t    size_r;
    scr_size_t    dec_size;
    logic [31:0]  instr_r;
    logic [31:0]  origin_r;
    logic [31:0]  target_r;
    logic [15:0]  tally_r;
    logic [31:0]  tgt_data_r;
    logic [31:0]  org_data_r;
    logic [31:0]  step;
    logic [31:0]  wmask;
    logic [7:0]   aw_addr_r;
    logic [31:0]  wdata_r;
    logic [3:0]   wstrb_r;
    logic [3:0]   test_r;
    logic         aw_got_r;
    logic         w_got_r;
    logic         wr_fire;
    logic         wr_hit;
    logic         start_wr;
    logic         dec_ok;
    logic         match;
    logic         exec;
    logic         last_step;
    logic         busy_r;
    logic         susp_r;
    logic         err_r;
    logic         done_r;

    assign wr_fire   = aw_got_r && w_got_r && !s_axi_bvalid;
    assign wmask     = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    assign wr_hit    = wr_fire && !busy_r;
    assign start_wr  = wr_hit && aw_addr_r[7:2] == `SCR_OFF_CTRL >> 2
                       && wstrb_r[0] && wdata_r[`SCR_CTRL_START];
    assign exec      = clk_en && state_r == ST_EXEC;
    assign last_step = match || tally_r == `SCR_TALLY_ONE;
    assign busy      = busy_r;
    assign mem_req   = mem_req_r;

    // instruction decode; register nibbles are only checked, the pointers live here
    always_comb begin
        dec_ok = (instr_r[15:9] == `SCR_OP_BW_TOP || instr_r[15:8] == `SCR_OP_LONG_TOP)
                 && instr_r[7:4] != `SCR_NIBBLE_ZERO && instr_r[3:0] == `SCR_OP_TAIL
                 && instr_r[31:28] == `SCR_OP2_TOP && instr_r[23:20] != `SCR_NIBBLE_ZERO;
        if (instr_r[15:8] == `SCR_OP_LONG_TOP) begin
            dec_size = SZ_LONG;
        end else if (instr_r[8]) begin
            dec_size = SZ_WORD;
        end else begin
            dec_size = SZ_BYTE;
        end
        unique case (size_r)
            SZ_BYTE: step = `SCR_STEP_BYTE;
            SZ_WORD: step = `SCR_STEP_WORD;
            SZ_LONG: step = `SCR_STEP_LONG;
            default: step = `SCR_STEP_BYTE;
        endcase
    end

    scr_compare u_compare (
        .target_elem (tgt_data_r),
        .origin_elem (org_data_r),
        .size        (size_r),
        .test_field  (test_r),
        .match       (match),
        .alu         (alu)
    );

    // write channel: address and data taken in either order
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `SCR_RESP_OKAY;
            aw_addr_r     <= 8'h00;
            wdata_r       <= `SCR_RST_WORD;
            wstrb_r       <= 4'h0;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r      <= 1'b1;
                s_axi_awready <= 1'b0;
                aw_addr_r     <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r      <= 1'b1;
                s_axi_wready <= 1'b0;
                wdata_r      <= s_axi_wdata;
                wstrb_r      <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_got_r      <= 1'b0;
                w_got_r       <= 1'b0;
                s_axi_bvalid  <= 1'b1;
                s_axi_bresp   <= (aw_addr_r[7:2] <= `SCR_OFF_TALLY >> 2 && aw_addr_r[7:2] != `SCR_OFF_STATUS >> 2)
                                 ? `SCR_RESP_OKAY : `SCR_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // read channel
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= `SCR_RST_WORD;
            s_axi_rresp   <= `SCR_RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= `SCR_RESP_OKAY;
                unique case ({s_axi_araddr[7:2], 2'b00})
                    `SCR_OFF_CTRL:   s_axi_rdata <= `SCR_RST_WORD;
                    `SCR_OFF_STATUS: s_axi_rdata <= {20'h0_0000, flags_r, 4'h0, done_r, err_r, susp_r, busy_r};
                    `SCR_OFF_INSTR:  s_axi_rdata <= instr_r;
                    `SCR_OFF_ORIGIN: s_axi_rdata <= origin_r;
                    `SCR_OFF_TARGET: s_axi_rdata <= target_r;
                    `SCR_OFF_TALLY:  s_axi_rdata <= {16'h0000, tally_r};
                    default: begin
                        s_axi_rdata <= `SCR_RST_WORD;
                        s_axi_rresp <= `SCR_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            instr_r <= `SCR_RST_WORD;
        end else if (clk_en && wr_hit && {aw_addr_r[7:2], 2'b00} == `SCR_OFF_INSTR) begin
            instr_r <= (instr_r & ~wmask) | (wdata_r & wmask);
        end
    end

    // pointers and tally stay put after a stop, so a restart resumes at the next element
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            origin_r <= `SCR_RST_WORD;
            target_r <= `SCR_RST_WORD;
            tally_r  <= `SCR_RST_TALLY;
        end else if (exec) begin
            origin_r <= origin_r + step;
            target_r <= target_r + step;
            tally_r  <= tally_r - `SCR_TALLY_ONE;
        end else if (clk_en && wr_hit) begin
            if ({aw_addr_r[7:2], 2'b00} == `SCR_OFF_ORIGIN) origin_r <= (origin_r & ~wmask) | (wdata_r & wmask);
            if ({aw_addr_r[7:2], 2'b00} == `SCR_OFF_TARGET) target_r <= (target_r & ~wmask) | (wdata_r & wmask);
            if ({aw_addr_r[7:2], 2'b00} == `SCR_OFF_TALLY)
                tally_r <= (tally_r & ~wmask[15:0]) | (wdata_r[15:0] & wmask[15:0]);
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            flags_r <= '0;
        end else if (exec) begin
            flags_r.c <= alu.c;
            flags_r.z <= match;
            flags_r.s <= alu.s;
            flags_r.v <= tally_r == `SCR_TALLY_ONE;
        end
    end

    // sequencer: two element reads, then one compare step
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_r    <= ST_IDLE;
            mem_req_r  <= '0;
            tgt_data_r <= `SCR_RST_WORD;
            org_data_r <= `SCR_RST_WORD;
            size_r     <= SZ_BYTE;
            test_r     <= 4'h0;
            busy_r     <= 1'b0;
            susp_r     <= 1'b0;
            err_r      <= 1'b0;
            done_r     <= 1'b0;
        end else if (clk_en) begin
            unique case (state_r)
                ST_IDLE: if (start_wr) begin
                    err_r  <= !dec_ok;
                    susp_r <= 1'b0;
                    done_r <= 1'b0;
                    if (dec_ok) begin
                        state_r <= ST_RD_TGT;
                        busy_r  <= 1'b1;
                        size_r  <= dec_size;
                        test_r  <= instr_r[19:16];
                    end
                end
                ST_RD_TGT: if (!mem_req_r.rd) begin
                    mem_req_r <= '{rd: 1'b1, addr: target_r, size: size_r};
                end else if (mem_rvalid) begin
                    mem_req_r.rd <= 1'b0;
                    tgt_data_r   <= mem_rdata;
                    state_r      <= ST_RD_ORG;
                end
                ST_RD_ORG: if (!mem_req_r.rd) begin
                    mem_req_r <= '{rd: 1'b1, addr: origin_r, size: size_r};
                end else if (mem_rvalid) begin
                    mem_req_r.rd <= 1'b0;
                    org_data_r   <= mem_rdata;
                    state_r      <= ST_EXEC;
                end
                ST_EXEC: begin
                    if (last_step) begin
                        state_r <= ST_IDLE;
                        busy_r  <= 1'b0;
                        done_r  <= 1'b1;
                    end else if (irq_req) begin
                        state_r <= ST_IDLE;
                        busy_r  <= 1'b0;
                        susp_r  <= 1'b1;
                    end else begin
                        state_r <= ST_RD_TGT;
                    end
                end
            endcase
        end
    end

    logic [7:0] diff8;
    assign diff8 = tgt_data_r[7:0] - org_data_r[7:0];

    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    a_ptr_step: assert property (exec |=> origin_r == $past(origin_r) + $past(step)
        && target_r == $past(target_r) + $past(step)) else $error("pointer step wrong");
    a_tally_dec: assert property (exec |=> tally_r == $past(tally_r) - 16'h0001)
        else $error("tally not decremented");
    a_one_compare: assert property (exec && tally_r == 16'h0001 |=> state_r == ST_IDLE && done_r)
        else $error("tally one did not end the run");
    a_match_end: assert property (exec && match |=> done_r && !busy_r && flags_r.z)
        else $error("match did not end the run");
    a_match_flag: assert property (exec && !match |=> !flags_r.z)
        else $error("match flag set without match");
    a_count_flag: assert property (exec |=> flags_r.v == ($past(tally_r) == 16'h0001))
        else $error("count flag wrong");
    a_borrow_byte: assert property (exec && size_r == SZ_BYTE
        |=> flags_r.c == ($past(tgt_data_r[7:0]) < $past(org_data_r[7:0]))) else $error("borrow flag wrong");
    a_sign_byte: assert property (exec && size_r == SZ_BYTE |=> flags_r.s == $past(diff8[7]))
        else $error("negative flag wrong");
    a_read_addr: assert property (mem_req_r.rd && state_r == ST_RD_ORG |-> mem_req_r.addr == origin_r)
        else $error("origin read at wrong address");
    a_irq_stop: assert property (exec && !last_step && irq_req |=> susp_r && state_r == ST_IDLE)
        else $error("interrupt not taken at step boundary");
    a_hold_susp: assert property (susp_r && state_r == ST_IDLE && !wr_fire
        |=> $stable(origin_r) && $stable(target_r) && $stable(tally_r)) else $error("suspended state changed");
    a_decode_err: assert property (clk_en && start_wr && !dec_ok |=> err_r && state_r == ST_IDLE)
        else $error("bad instruction accepted");

    c_count_end: cover property (exec && tally_r == 16'h0001 && !match);
    c_match_end: cover property (exec && match && size_r == SZ_WORD);
    c_suspend: cover property (exec && !last_step && irq_req);
    c_long_run: cover property (exec && size_r == SZ_LONG ##1 state_r == ST_RD_TGT);
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
`include "scr_params.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import scr_pkg::*;

    logic         clock;
    logic         reset_n;
    logic         clk_en;
    logic         irq_req;
    logic [7:0]   awaddr;
    logic         awvalid;
    logic         awready;
    logic [31:0]  wdata;
    logic [3:0]   wstrb;
    logic         wvalid;
    logic         wready;
    logic [1:0]   bresp;
    logic         bvalid;
    logic         bready;
    logic [7:0]   araddr;
    logic         arvalid;
    logic         arready;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
    logic         rvalid;
    logic         rready;
    scr_mem_req_t mem_req;
    logic [31:0]  mem_rdata;
    logic         mem_rvalid;
    logic         busy;
    logic [31:0]  store [logic [31:0]];
    logic [31:0]  alog [$];
    logic [31:0]  bad [2];
    int           mem_dly;
    int           wcnt;
    int           mismatches;
    int           n_tests;
    logic [31:0]  sv;
    logic [1:0]   sr;
    scr_size_t    exp_sz;
    // match per condition code for a byte 1 minus 2: borrow, negative, no overflow
    localparam logic [15:0] cc_mask = 16'h51AE;

    scr_string_compare_repeat uut (
        .clock         (clock),
        .reset_n       (reset_n),
        .clk_en        (clk_en),
        .irq_req       (irq_req),
        .s_axi_awaddr  (awaddr),
        .s_axi_awvalid (awvalid),
        .s_axi_awready (awready),
        .s_axi_wdata   (wdata),
        .s_axi_wstrb   (wstrb),
        .s_axi_wvalid  (wvalid),
        .s_axi_wready  (wready),
        .s_axi_bresp   (bresp),
        .s_axi_bvalid  (bvalid),
        .s_axi_bready  (bready),
        .s_axi_araddr  (araddr),
        .s_axi_arvalid (arvalid),
        .s_axi_arready (arready),
        .s_axi_rdata   (rdata),
        .s_axi_rresp   (rresp),
        .s_axi_rvalid  (rvalid),
        .s_axi_rready  (rready),
        .mem_req       (mem_req),
        .mem_rdata     (mem_rdata),
        .mem_rvalid    (mem_rvalid),
        .busy          (busy)
    );

    always #5 clock = ~clock;

    // memory answers after mem_dly idle cycles; data inverted once released
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mem_rvalid <= 1'b0;
            mem_rdata <= 32'h0000_0000;
            wcnt <= 0;
        end else if (mem_rvalid) begin
            mem_rvalid <= 1'b0;
            mem_rdata <= ~mem_rdata;
        end else if (mem_req.rd === 1'b1 && wcnt >= mem_dly) begin
            mem_rvalid <= 1'b1;
            mem_rdata <= store.exists(mem_req.addr) ? store[mem_req.addr] : 32'h0000_0000;
            wcnt <= 0;
        end else if (mem_req.rd === 1'b1) begin
            wcnt <= wcnt + 1;
        end
    end

    always @(posedge clock) begin
        if (reset_n && clk_en && mem_req.rd === 1'b1 && mem_rvalid) begin
            alog.push_back(mem_req.addr);
            chk({30'h0, mem_req.size}, {30'h0, exp_sz});
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit ad;
        bit wd;
        ad = 0;
        wd = 0;
        @(posedge clock);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge clock);
            if (!ad && awready === 1'b1) begin
                ad = 1;
                awvalid <= 1'b0;
            end
            if (!wd && wready === 1'b1) begin
                wd = 1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clock); while (bvalid !== 1'b1);
        chk({30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
    endtask

    task automatic get(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clock); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clock); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        get(a, sv, sr);
        chk(sv, e);
        chk({30'h0, sr}, {30'h0, er});
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (busy !== 1'b0 && n < 3000);
        chk({31'h0, busy}, 32'h0000_0000);
    endtask

    task automatic start(input logic [31:0] ins, input logic [31:0] tg, input logic [31:0] og,
                         input logic [31:0] ta);
        wr(`SCR_OFF_ORIGIN, og, `SCR_RESP_OKAY);
        wr(`SCR_OFF_TARGET, tg, `SCR_RESP_OKAY);
        wr(`SCR_OFF_TALLY, ta, `SCR_RESP_OKAY);
        wr(`SCR_OFF_INSTR, ins, `SCR_RESP_OKAY);
        alog.delete();
        wr(`SCR_OFF_CTRL, 32'h0000_0001, `SCR_RESP_OKAY);
    endtask

    // target element read before origin element, both advancing by step
    task automatic chk_log(input logic [31:0] tg, input logic [31:0] og, input logic [31:0] step, input int n);
        chk(32'(alog.size()), 32'(2 * n));
        for (int i = 0; i < n && 2 * i + 1 < alog.size(); i++) begin
            chk(alog[2 * i], tg + i * step);
            chk(alog[2 * i + 1], og + i * step);
        end
    endtask

    task automatic results(input logic [31:0] tg, input logic [31:0] og, input logic [31:0] ta,
                           input logic [31:0] st);
        rd(`SCR_OFF_ORIGIN, og, `SCR_RESP_OKAY);
        rd(`SCR_OFF_TARGET, tg, `SCR_RESP_OKAY);
        rd(`SCR_OFF_TALLY, ta, `SCR_RESP_OKAY);
        rd(`SCR_OFF_STATUS, st, `SCR_RESP_OKAY);
    endtask

    task automatic put(input logic [31:0] base, input logic [31:0] step, input logic [31:0] v [3]);
        for (int i = 0; i < 3; i++) begin
            store[base + i * step] = v[i];
        end
    endtask

    function automatic logic [31:0] enc(input scr_size_t sz, input logic [3:0] cc, input logic [3:0] rs);
        logic [15:0] w1;
        if (sz == SZ_LONG) w1 = {8'hB9, rs, 4'h6};
        else w1 = {7'h5D, sz[0], rs, 4'h6};
        return {4'h0, 4'h3, 4'h2, cc, w1};
    endfunction

    task automatic print_verdict();
        if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        print_verdict();
    end

    initial begin
        clock = 1'b0;
        reset_n = 1'b0;
        clk_en = 1'b1;
        irq_req = 1'b0;
        awaddr = 8'h00;
        awvalid = 1'b0;
        wdata = 32'h0000_0000;
        wstrb = 4'hF;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = 8'h00;
        arvalid = 1'b0;
        rready = 1'b0;
        mem_dly = 0;
        exp_sz = SZ_BYTE;
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd(8'(4 * i), 32'h0000_0000, `SCR_RESP_OKAY);
        end
        wr(`SCR_OFF_TALLY, 32'hFFFF_1234, `SCR_RESP_OKAY);
        rd(`SCR_OFF_TALLY, 32'h0000_1234, `SCR_RESP_OKAY);
        // only the strobed byte lands
        wstrb <= 4'h2;
        wr(`SCR_OFF_TALLY, 32'h0000_AB00, `SCR_RESP_OKAY);
        wstrb <= 4'hF;
        rd(`SCR_OFF_TALLY, 32'h0000_AB34, `SCR_RESP_OKAY);
        wr(`SCR_OFF_STATUS, 32'h0000_000F, `SCR_RESP_SLVERR);
        wr(8'h1C, 32'h0000_0001, `SCR_RESP_SLVERR);
        rd(8'h18, 32'h0000_0000, `SCR_RESP_SLVERR);
        // byte run, slow memory, stops on the third element; tally write while busy is dropped
        mem_dly <= 2;
        put(32'h0000_0100, 32'h0000_0001, '{32'h0000_0005, 32'h0000_0007, 32'h0000_0009});
        put(32'h0000_0200, 32'h0000_0001, '{32'h0000_0001, 32'h0000_0002, 32'h0000_0009});
        start(enc(SZ_BYTE, 4'h6, 4'h1), 32'h0000_0100, 32'h0000_0200, 32'h0000_0004);
        wr(`SCR_OFF_TALLY, 32'h0000_0055, `SCR_RESP_OKAY);
        wait_idle();
        chk_log(32'h0000_0100, 32'h0000_0200, 32'h0000_0001, 3);
        results(32'h0000_0103, 32'h0000_0203, 32'h0000_0001, 32'h0000_0408);
        // word run of length one; upper garbage must be ignored
        exp_sz = SZ_WORD;
        put(32'h0000_0300, 32'h0000_0002, '{32'hABCD_0001, 32'h0000_0000, 32'h0000_0000});
        put(32'h0000_0400, 32'h0000_0002, '{32'h5555_0002, 32'h0000_0000, 32'h0000_0000});
        start(enc(SZ_WORD, 4'h0, 4'h3), 32'h0000_0300, 32'h0000_0400, 32'h0000_0001);
        wait_idle();
        chk_log(32'h0000_0300, 32'h0000_0400, 32'h0000_0002, 1);
        results(32'h0000_0302, 32'h0000_0402, 32'h0000_0000, 32'h0000_0B08);
        // longword run, fast memory, condition true on first element
        mem_dly <= 0;
        exp_sz = SZ_LONG;
        put(32'h0000_0500, 32'h0000_0004, '{32'h8000_0000, 32'h0000_0000, 32'h0000_0000});
        put(32'h0000_0600, 32'h0000_0004, '{32'h0000_0001, 32'h0000_0000, 32'h0000_0000});
        start(enc(SZ_LONG, 4'hE, 4'h5), 32'h0000_0500, 32'h0000_0600, 32'h0000_0003);
        // frozen long enough that a live run would have ended
        clk_en <= 1'b0;
        repeat (20) @(posedge clock);
        chk({31'h0, busy}, 32'h0000_0001);
        clk_en <= 1'b1;
        wait_idle();
        chk_log(32'h0000_0500, 32'h0000_0600, 32'h0000_0004, 1);
        results(32'h0000_0504, 32'h0000_0604, 32'h0000_0002, 32'h0000_0408);
        // interrupted after one step, then resumed to the end
        exp_sz = SZ_BYTE;
        put(32'h0000_0700, 32'h0000_0001, '{32'h0000_0001, 32'h0000_0001, 32'h0000_0001});
        put(32'h0000_0800, 32'h0000_0001, '{32'h0000_0001, 32'h0000_0001, 32'h0000_0001});
        irq_req <= 1'b1;
        start(enc(SZ_BYTE, 4'h0, 4'h2), 32'h0000_0700, 32'h0000_0800, 32'h0000_0003);
        wait_idle();
        chk(32'(alog.size()), 32'h0000_0002);
        results(32'h0000_0701, 32'h0000_0801, 32'h0000_0002, 32'h0000_0002);
        irq_req <= 1'b0;
        wr(`SCR_OFF_CTRL, 32'h0000_0001, `SCR_RESP_OKAY);
        wait_idle();
        chk_log(32'h0000_0700, 32'h0000_0800, 32'h0000_0001, 3);
        results(32'h0000_0703, 32'h0000_0803, 32'h0000_0000, 32'h0000_0108);
        // every condition code on one byte pair, single element
        put(32'h0000_0B00, 32'h0000_0001, '{32'h0000_0001, 32'h0000_0000, 32'h0000_0000});
        put(32'h0000_0C00, 32'h0000_0001, '{32'h0000_0002, 32'h0000_0000, 32'h0000_0000});
        for (int k = 0; k < 16; k++) begin
            start(enc(SZ_BYTE, 4'(k), 4'h1), 32'h0000_0B00, 32'h0000_0C00, 32'h0000_0001);
            wait_idle();
            rd(`SCR_OFF_STATUS, 32'h0000_0B08 | (32'(cc_mask[k]) << 10), `SCR_RESP_OKAY);
        end
        // zero origin field and the non-repeating form are both refused
        bad[0] = enc(SZ_WORD, 4'h6, 4'h0);
        bad[1] = enc(SZ_BYTE, 4'h6, 4'h1) ^ 32'h0000_0004;
        for (int i = 0; i < 2; i++) begin
            start(bad[i], 32'h0000_0900, 32'h0000_0A00, 32'h0000_0002);
            repeat (10) @(posedge clock);
            get(`SCR_OFF_STATUS, sv, sr);
            chk({28'h0, sv[3:0]}, 32'h0000_0004);
            chk(32'(alog.size()), 32'h0000_0000);
        end
        print_verdict();
    end
endmodule
`default_nettype wire
